// File: include/rssf_defines.svh
// offsets, field positions, reset values and opcodes for the rotate/shift/subtract flag unit
`ifndef RSSF_DEFINES_SVH
`define RSSF_DEFINES_SVH
`define FLAG_C           7
`define FLAG_Z           6
`define FLAG_S           5
`define FLAG_V           4
`define FLAG_D           3
`define FLAG_H           2
`define FLAG_BANK        0
`define FLAGS_RESET      8'h00
`define OP_RLC_R         8'h10
`define OP_RLC_IR        8'h11
`define OP_RR_R          8'he0
`define OP_RR_IR         8'he1
`define OP_RRC_R         8'hc0
`define OP_RRC_IR        8'hc1
`define OP_SRA_R         8'hd0
`define OP_SRA_IR        8'hd1
`define OP_SBC_RR        8'h32
`define OP_SBC_R_R       8'h34
`define OP_SBC_R_IM      8'h36
`define OP_BANK0         8'h4f
`define OP_BANK1         8'h5f
`define OP_SETC          8'hdf
`define REG_CTRL         12'h000
`define REG_FLAGS        12'h004
`define REG_OPND         12'h008
`define REG_RESULT       12'h00c
`define REG_STATUS       12'h010
`define AXI_OKAY         2'b00
`define AXI_SLVERR       2'b10
`endif

// File: include/rssf_pkg.sv
// types shared by the rotate/shift/subtract flag unit
package rssf_pkg;
	typedef enum logic [3:0] {
		op_none,
		rotate_left_thru_carry,
		rotate_right_op,
		rotate_right_thru_carry,
		shift_right_arith,
		subtract_with_borrow,
		select_bank_zero,
		select_bank_one,
		set_carry_op
	} op_type;
	typedef struct packed {
		logic [7:0] value;
		logic [7:0] flags;
		logic       write_dst;
	} result_type;
endpackage

// File: src/rssf_alu.sv
// combinational operation core: result byte and new flags
`timescale 1ns/1ns
`include "rssf_defines.svh"
module rssf_alu (
	input  wire rssf_pkg::op_type     op,
	input  wire logic [7:0]           dst,
	input  wire logic [7:0]           src,
	input  wire logic [7:0]           flags,
	output rssf_pkg::result_type      res
);
	logic [8:0] diff;
	logic [4:0] low;
	logic       c;
	always_comb begin
		c = flags[`FLAG_C];
		diff = {1'b0, dst} - {1'b0, src} - {8'h00, c};
		low = {1'b0, dst[3:0]} - {1'b0, src[3:0]} - {4'h0, c};
		res.value = dst;
		res.flags = flags;
		res.write_dst = 1'b0;
		unique case (op)
			rssf_pkg::rotate_left_thru_carry: begin
				res.value = {dst[6:0], c};
				res.flags[`FLAG_C] = dst[7];
				res.write_dst = 1'b1;
			end
			rssf_pkg::rotate_right_op: begin
				res.value = {dst[0], dst[7:1]};
				res.flags[`FLAG_C] = dst[0];
				res.write_dst = 1'b1;
			end
			rssf_pkg::rotate_right_thru_carry: begin
				res.value = {c, dst[7:1]};
				res.flags[`FLAG_C] = dst[0];
				res.write_dst = 1'b1;
			end
			rssf_pkg::shift_right_arith: begin
				res.value = {dst[7], dst[7:1]};
				res.flags[`FLAG_C] = dst[0];
				res.flags[`FLAG_V] = 1'b0;
				res.write_dst = 1'b1;
			end
			rssf_pkg::subtract_with_borrow: begin
				res.value = diff[7:0];
				res.flags[`FLAG_C] = diff[8];
				// opposite operand signs, result sign follows the source
				res.flags[`FLAG_V] = (dst[7] ^ src[7]) & (diff[7] == src[7]);
				res.flags[`FLAG_D] = 1'b1;
				res.flags[`FLAG_H] = low[4];
				res.write_dst = 1'b1;
			end
			rssf_pkg::select_bank_zero: res.flags[`FLAG_BANK] = 1'b0;
			rssf_pkg::select_bank_one:  res.flags[`FLAG_BANK] = 1'b1;
			rssf_pkg::set_carry_op:     res.flags[`FLAG_C] = 1'b1;
			default: ;
		endcase
		if (res.write_dst) begin
			res.flags[`FLAG_Z] = (res.value == 8'h00);
			res.flags[`FLAG_S] = res.value[7];
			if (op != rssf_pkg::subtract_with_borrow && op != rssf_pkg::shift_right_arith)
				res.flags[`FLAG_V] = res.value[7] ^ dst[7];
		end
	end
endmodule

// File: src/rssf_unit.sv
// rotate/shift/subtract flag unit with an axi4-lite register port
// Operation
// - rotate left through carry, bit 7 to carry
// - rotate right, bit 0 to 7 and carry
// - rotate right through carry, carry to bit 7
// - rotates set overflow when sign changes
// - rotates set zero, sign; keep decimal, half
// - bank-0 select clears bank flag only
// - bank-1 select sets bank flag only
// - subtract destination minus source minus carry
// - subtract sets carry on borrow, zero, sign
// - subtract overflow from operand and result signs
// - subtract forces decimal, half shows nibble borrow
// - set-carry forces carry, others unchanged
// - arithmetic shift right keeps bit 7
// - shift sets carry, zero, sign; clears overflow
`timescale 1ns/1ns
`include "rssf_defines.svh"
module rssf_unit (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        exec_valid,
	input  wire logic [7:0]  exec_opcode,
	input  wire logic [7:0]  exec_dst,
	input  wire logic [7:0]  exec_src,
	output logic             wb_valid,
	output logic             wb_write_dst,
	output logic [7:0]       wb_value,
	output logic [7:0]       flags
);
	rssf_pkg::op_type     op;
	rssf_pkg::result_type res;
	logic [7:0]  opnd_dst;
	logic [7:0]  opnd_src;
	logic [7:0]  next_flags;
	logic        next_wb_valid;
	logic        next_wb_write_dst;
	logic [7:0]  next_wb_value;
	logic [7:0]  next_opnd_dst;
	logic [7:0]  next_opnd_src;
	logic [7:0]  reg_opcode;
	logic        sw_go;
	logic        aw_held;
	logic        w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        next_aw_held;
	logic        next_w_held;
	logic [11:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0]  next_w_strb;
	logic        next_awready;
	logic        next_wready;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic        do_write;
	logic [7:0]  cur_opcode;
	logic [7:0]  cur_dst;
	logic [7:0]  cur_src;
	logic        cur_valid;
	logic [7:0]  wr_byte;

	// decoder port wins over a software-issued operation in the same cycle
	always_comb begin
		cur_valid = exec_valid | sw_go;
		cur_opcode = exec_valid ? exec_opcode : reg_opcode;
		cur_dst = exec_valid ? exec_dst : opnd_dst;
		cur_src = exec_valid ? exec_src : opnd_src;
		op = rssf_pkg::op_none;
		if (cur_valid) begin
			unique case (cur_opcode)
				`OP_RLC_R, `OP_RLC_IR: op = rssf_pkg::rotate_left_thru_carry;
				`OP_RR_R, `OP_RR_IR: op = rssf_pkg::rotate_right_op;
				`OP_RRC_R, `OP_RRC_IR: op = rssf_pkg::rotate_right_thru_carry;
				`OP_SRA_R, `OP_SRA_IR: op = rssf_pkg::shift_right_arith;
				`OP_SBC_RR, `OP_SBC_R_R, `OP_SBC_R_IM: op = rssf_pkg::subtract_with_borrow;
				`OP_BANK0: op = rssf_pkg::select_bank_zero;
				`OP_BANK1: op = rssf_pkg::select_bank_one;
				`OP_SETC: op = rssf_pkg::set_carry_op;
				default: op = rssf_pkg::op_none;
			endcase
		end
	end

	rssf_alu alu (
		.op    (op),
		.dst   (cur_dst),
		.src   (cur_src),
		.flags (flags),
		.res   (res)
	);

	// axi write path: address and data taken in either order
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		do_write = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (aw_held && w_held && !s_axi_bvalid) begin
			do_write = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			unique case (aw_addr)
				`REG_CTRL, `REG_FLAGS, `REG_OPND: next_bresp = `AXI_OKAY;
				default: next_bresp = `AXI_SLVERR;
			endcase
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
	end

	always_comb begin
		wr_byte = w_strb[0] ? w_data[7:0] : 8'h00;
		next_flags = flags;
		next_wb_valid = cur_valid;
		next_wb_write_dst = wb_write_dst;
		next_wb_value = wb_value;
		next_opnd_dst = opnd_dst;
		next_opnd_src = opnd_src;
		if (cur_valid) begin
			next_flags = res.flags;
			next_wb_value = res.value;
			// destination flag stands with the value so the result register stays readable
			next_wb_write_dst = res.write_dst;
		end else if (do_write && aw_addr == `REG_FLAGS && w_strb[0]) begin
			next_flags = wr_byte;
		end
		if (do_write && aw_addr == `REG_OPND) begin
			if (w_strb[0])
				next_opnd_dst = w_data[7:0];
			if (w_strb[1])
				next_opnd_src = w_data[15:8];
		end
	end

	// axi read path: one read at a time, answer one cycle after address
	always_comb begin
		next_arready = s_axi_arready;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rresp = `AXI_OKAY;
			unique case (s_axi_araddr)
				`REG_CTRL: next_rdata = {24'h000000, reg_opcode};
				`REG_FLAGS: next_rdata = {24'h000000, flags};
				`REG_OPND: next_rdata = {16'h0000, opnd_src, opnd_dst};
				`REG_RESULT: next_rdata = {23'h000000, wb_write_dst, wb_value};
				`REG_STATUS: next_rdata = {31'h00000000, wb_valid};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = `AXI_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= `FLAGS_RESET;
			wb_valid <= 1'b0;
			wb_write_dst <= 1'b0;
			wb_value <= 8'h00;
			opnd_dst <= 8'h00;
			opnd_src <= 8'h00;
			reg_opcode <= 8'h00;
			sw_go <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AXI_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AXI_OKAY;
		end else begin
			flags <= next_flags;
			wb_valid <= next_wb_valid;
			wb_write_dst <= next_wb_write_dst;
			wb_value <= next_wb_value;
			opnd_dst <= next_opnd_dst;
			opnd_src <= next_opnd_src;
			// writing the control register launches one operation next cycle
			sw_go <= do_write && aw_addr == `REG_CTRL && w_strb[0];
			if (do_write && aw_addr == `REG_CTRL && w_strb[0])
				reg_opcode <= w_data[7:0];
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	a_sbc_result: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid && exec_opcode == `OP_SBC_RR |=> wb_value ==
		8'($past(exec_dst) - $past(exec_src) - {7'h00, $past(flags[`FLAG_C])}))
		else $error("subtract result wrong");
	a_sbc_dflag: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid && exec_opcode == `OP_SBC_R_IM |=> flags[`FLAG_D])
		else $error("subtract left decimal flag clear");
	a_rlc_carry: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid && exec_opcode == `OP_RLC_R |=>
		flags[`FLAG_C] == $past(exec_dst[7]) && wb_value[0] == $past(flags[`FLAG_C]))
		else $error("rotate left carry wrong");
	a_rr_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid && exec_opcode == `OP_RR_R |=>
		wb_value[7] == $past(exec_dst[0]) && flags[`FLAG_C] == $past(exec_dst[0]))
		else $error("rotate right wrap wrong");
	a_rrc_carry: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid && exec_opcode == `OP_RRC_IR |=> wb_value[7] == $past(flags[`FLAG_C]))
		else $error("rotate right through carry wrong");
	a_rot_keep_dh: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid && exec_opcode == `OP_RR_IR |=> $stable(flags[`FLAG_D:`FLAG_H]))
		else $error("rotate changed decimal or half flag");
	a_bank_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid && exec_opcode == `OP_BANK0 |=>
		!flags[`FLAG_BANK] && flags[7:1] == $past(flags[7:1]))
		else $error("bank zero select wrong");
	a_bank_one: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid && exec_opcode == `OP_BANK1 |=>
		flags[`FLAG_BANK] && flags[7:1] == $past(flags[7:1]))
		else $error("bank one select wrong");
	a_set_carry: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid && exec_opcode == `OP_SETC |=>
		flags[`FLAG_C] && flags[6:0] == $past(flags[6:0]))
		else $error("set carry wrong");
	a_sra_sign: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid && exec_opcode == `OP_SRA_R |=>
		wb_value[7:6] == {2{$past(exec_dst[7])}} && !flags[`FLAG_V])
		else $error("arithmetic shift wrong");
	a_wb_together: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_valid |=> wb_valid && (!wb_write_dst ||
		(flags[`FLAG_Z] == (wb_value == 8'h00) && flags[`FLAG_S] == wb_value[7])))
		else $error("writeback flags and value apart");
endmodule

// File: sim/rssf_decoder_model.sv
// decoder and register file stand-in that issues operations to the unit
`timescale 1ns/1ns
module rssf_decoder_model (
	input  wire logic       aclk,
	output logic            exec_valid,
	output logic [7:0]      exec_opcode,
	output logic [7:0]      exec_dst,
	output logic [7:0]      exec_src
);
	initial begin
		exec_valid = 1'b0;
		exec_opcode = 8'h00;
		exec_dst = 8'h00;
		exec_src = 8'h00;
	end

	// hold keeps valid up so the next call lands back to back
	task automatic send(input logic [7:0] o, input logic [7:0] d, input logic [7:0] s,
		input bit hold);
		@(posedge aclk);
		exec_valid <= 1'b1;
		exec_opcode <= o;
		exec_dst <= d;
		exec_src <= s;
		if (!hold) begin
			@(posedge aclk);
			exec_valid <= 1'b0;
			// operands go stale once taken: show their inverse
			exec_dst <= ~d;
			exec_src <= ~s;
		end
	endtask
endmodule

// File: sim/rotate_shift_subtract_flag_unit_test.sv
// self-checking bench for the rotate/shift/subtract flag unit
`timescale 1ns/1ns
`include "rssf_defines.svh"
module rotate_shift_subtract_flag_unit_test;
	logic        aclk, aresetn, exec_valid, wb_valid, wb_write_dst;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [7:0]  exec_opcode, exec_dst, exec_src, wb_value, flags, exp_f;
	logic [16:0] wbq[$], e1, e2;
	int          miscompares, total_checks;

	rssf_unit i_rssf_unit (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .exec_valid(exec_valid), .exec_opcode(exec_opcode),
		.exec_dst(exec_dst), .exec_src(exec_src), .wb_valid(wb_valid),
		.wb_write_dst(wb_write_dst), .wb_value(wb_value), .flags(flags));
	rssf_decoder_model i_rssf_decoder_model (.aclk(aclk), .exec_valid(exec_valid),
		.exec_opcode(exec_opcode), .exec_dst(exec_dst), .exec_src(exec_src));

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// collect every write-back as {write_dst, value, flags}
	always @(negedge aclk) begin
		if (wb_valid === 1'b1) wbq.push_back({wb_write_dst, wb_value, flags});
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic hang;
		miscompares++;
		$display("wrong value at %0t: no answer", $time);
		close_out;
	endtask

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	// reference result: {write_dst, value, flags}
	function automatic logic [16:0] expect_op(input logic [7:0] o, input logic [7:0] d,
		input logic [7:0] s, input logic [7:0] f);
		logic [7:0] r, n;
		logic [8:0] t;
		logic [4:0] h;
		logic       w;
		n = f;
		r = d;
		w = 1'b1;
		case (o)
			8'h10, 8'h11: begin r = {d[6:0], f[7]}; n[7] = d[7]; end
			8'he0, 8'he1: begin r = {d[0], d[7:1]}; n[7] = d[0]; end
			8'hc0, 8'hc1: begin r = {f[7], d[7:1]}; n[7] = d[0]; end
			8'hd0, 8'hd1: begin r = {d[7], d[7:1]}; n[7] = d[0]; end
			8'h32, 8'h34, 8'h36: begin
				t = {1'b0, d} - {1'b0, s} - {8'h00, f[7]};
				h = {1'b0, d[3:0]} - {1'b0, s[3:0]} - {4'h0, f[7]};
				r = t[7:0];
				n[7] = t[8];
				n[3] = 1'b1;
				n[2] = h[4];
			end
			8'h4f: begin n[0] = 1'b0; w = 1'b0; end
			8'h5f: begin n[0] = 1'b1; w = 1'b0; end
			8'hdf: begin n[7] = 1'b1; w = 1'b0; end
			default: w = 1'b0;
		endcase
		if (w) begin
			n[6] = (r == 8'h00);
			n[5] = r[7];
			if (o[7:4] == 4'hd) n[4] = 1'b0;
			else if (o[7:4] == 4'h3) n[4] = (d[7] != s[7]) && (r[7] == s[7]);
			else n[4] = r[7] ^ d[7];
		end
		return {w, r, n};
	endfunction

	task automatic grab(input logic [16:0] e, input string m);
		int n;
		for (n = 0; n < 20 && wbq.size() == 0; n++) @(negedge aclk);
		if (wbq.size() == 0) hang;
		check_val({15'h0, wbq.pop_front()}, {15'h0, e}, m);
		exp_f = e[7:0];
	endtask

	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int  n;
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (!ad && s_axi_awready === 1'b1) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
			if (!wd && s_axi_wready === 1'b1) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
			if (s_axi_bvalid === 1'b1) begin r = s_axi_bresp; s_axi_bready <= 1'b0; return; end
		end
		hang;
	endtask

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int  n;
		logic ad;
		ad = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (!ad && s_axi_arready === 1'b1) begin ad = 1'b1; s_axi_arvalid <= 1'b0; end
			if (s_axi_rvalid === 1'b1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				return;
			end
		end
		hang;
	endtask

	// edge operands: sign flips, zero results, borrows in both nibbles
	task automatic op_sweep(input logic [7:0] o);
		logic [7:0] dl[6];
		int  k;
		dl = '{8'haa, 8'h55, 8'h01, 8'h80, 8'h00, 8'hff};
		for (k = 0; k < 6; k++) begin
			i_rssf_decoder_model.send(o, dl[k], dl[k] ^ 8'h5c, 1'b0);
			grab(expect_op(o, dl[k], dl[k] ^ 8'h5c, exp_f), "op result");
		end
	endtask

	task automatic back_to_back;
		e1 = expect_op(8'h10, 8'haa, 8'h00, exp_f);
		e2 = expect_op(8'hdf, 8'h11, 8'h00, e1[7:0]);
		i_rssf_decoder_model.send(8'h10, 8'haa, 8'h00, 1'b1);
		i_rssf_decoder_model.send(8'hdf, 8'h11, 8'h00, 1'b0);
		grab(e1, "first of pair");
		grab(e2, "second of pair");
	endtask

	// software path: operands, launch, result and refused accesses
	task automatic register_path;
		axi_write(`REG_OPND, 32'h00003c81, rs);
		axi_read(`REG_OPND, rd, rs);
		check_val(rd, 32'h00003c81, "operand read back");
		axi_write(`REG_CTRL, 32'h000000c0, rs);
		e1 = expect_op(8'hc0, 8'h81, 8'h3c, exp_f);
		grab(e1, "register launch");
		axi_read(`REG_RESULT, rd, rs);
		check_val({23'h0, rd[8:0]}, {23'h0, e1[16:8]}, "result register");
		axi_read(`REG_CTRL, rd, rs);
		check_val(rd, 32'h000000c0, "control read back");
		axi_read(12'h020, rd, rs);
		check_val({rs, rd[29:0]}, 32'h80000000, "unmapped read");
		axi_write(`REG_RESULT, 32'h000000ff, rs);
		check_val({30'h0, rs}, 32'h2, "read-only write resp");
		@(negedge aclk);
		check_val({24'h0, flags}, {24'h0, exp_f}, "flags after refused write");
	endtask

	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		miscompares = 0;
		total_checks = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check_val({24'h0, flags}, 32'h0, "reset flags");
		check_val({31'h0, s_axi_awready}, 32'h1, "reset awready");
		axi_write(`REG_FLAGS, 32'h00000082, rs);
		check_val({30'h0, rs}, 32'h0, "flags write resp");
		axi_read(`REG_FLAGS, rd, rs);
		check_val({24'h0, rd[7:0]}, 32'h82, "flags read back");
		exp_f = 8'h82;
		op_sweep(8'h10);
		op_sweep(8'h11);
		op_sweep(8'he0);
		op_sweep(8'he1);
		op_sweep(8'hc0);
		op_sweep(8'hc1);
		op_sweep(8'hd0);
		op_sweep(8'hd1);
		op_sweep(8'h32);
		op_sweep(8'h34);
		op_sweep(8'h36);
		op_sweep(8'h5f);
		op_sweep(8'h4f);
		op_sweep(8'hdf);
		op_sweep(8'h36);
		op_sweep(8'h00);
		back_to_back;
		register_path;
		close_out;
	end
endmodule
